// ---- table_lookup_interpolator_bench.sv ----
// Self-checking bench for the interpolation datapath
`timescale 1ns/1ps
`default_nettype none
module table_lookup_interpolator_bench;
	import tli_pkg::*;
	logic clk_i, reset_n_i, ce_i, req_valid_i, rsp_valid_o, have_ofs;
	tli_req_t req_i, r;
	tli_rsp_t rsp_o;
	logic [7:0] entry_offset_o, ofs_exp;
	tli_rsp_t q[$];
	int error_cnt, n_compared, cyc, k;
	int seed = 32'h8df929fd;
	tli_core tli_core_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
		.req_valid_i(req_valid_i), .req_i(req_i), .entry_offset_o(entry_offset_o),
		.rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o));
	// Clock and hang guard
	initial begin
		clk_i = 0;
		forever #50 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc++;
		if (cyc > 3000) begin
			error_cnt++;
			wrap_up();
		end
	end
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("Compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Truncate to operand size, then sign or zero extend
	function automatic logic signed [63:0] ext(input logic [31:0] v, input int w, input bit s);
		logic signed [63:0] x;
		x = v & ((64'sd1 << w) - 1);
		if (s && x[w-1]) x = x - (64'sd1 << w);
		return x;
	endfunction
	// Reference result with round to nearest even
	function automatic tli_rsp_t calc(input tli_req_t a);
		logic signed [63:0] lo, hi, u, qv;
		int w;
		w = (a.size == TLI_SZ_BYTE) ? 8 : (a.size == TLI_SZ_WORD) ? 16 : 32;
		lo = ext(a.entry_lo, w, !a.variant[1]);
		hi = ext(a.entry_hi, w, !a.variant[1]);
		u = lo * 256 + $signed({56'd0, a.indep[7:0]}) * (hi - lo);
		qv = u >>> 8;
		if (u[7:0] > 8'h80 || (u[7:0] == 8'h80 && qv[0])) qv = qv + 1;
		return {a.variant[0] ? u[39:0] : qv[39:0], a.pair_mode};
	endfunction
	function automatic tli_req_t mk(input logic [1:0] v, input logic [1:0] s,
		input logic [15:0] x, input logic [31:0] l, input logic [31:0] h, input logic p);
		return {tli_variant_t'(v), tli_size_t'(s), x, l, h, p};
	endfunction
	// Drive one cycle; a taken request notes its expected answer
	task automatic send(input tli_req_t a, input logic c);
		@(posedge clk_i);
		#1;
		req_valid_i = 1;
		req_i = a;
		ce_i = c;
		if (c) q.push_back(calc(a));
	endtask
	// Watch outputs mid-cycle, where they are settled
	always @(negedge clk_i) if (reset_n_i) begin
		if (have_ofs) chk(entry_offset_o, ofs_exp);
		if (rsp_valid_o && ce_i) begin
			if (q.size() == 0) chk(1, 0);
			else chk(rsp_o, q.pop_front());
		end
		if (ce_i && req_valid_i) begin
			ofs_exp = req_i.indep[15:8];
			have_ofs = 1;
		end
	end
	initial begin
		{reset_n_i, req_valid_i, have_ofs} = 0;
		ce_i = 1;
		req_i = '0;
		repeat (3) @(posedge clk_i);
		#1;
		chk({rsp_valid_o, entry_offset_o, rsp_o}, 0);
		reset_n_i = 1;
		// Worked table cases, ties, truncation and pair operands
		send(mk(2'h0, 2'h1, 16'ha380, 32'h00000685, 32'h0000068f, 1'b0), 1'b1);
		send(mk(2'h0, 2'h1, 16'h028e, 32'h0000051f, 32'h000007ae, 1'b0), 1'b1);
		send(mk(2'h1, 2'h1, 16'h0bd0, 32'h00000050, 32'h00000040, 1'b0), 1'b1);
		send(mk(2'h2, 2'h0, 16'h0080, 32'h00000002, 32'h00000003, 1'b1), 1'b1);
		send(mk(2'h2, 2'h0, 16'h0080, 32'h00000003, 32'h00000004, 1'b1), 1'b1);
		send(mk(2'h0, 2'h0, 16'h0080, 32'h123456ff, 32'h00000000, 1'b1), 1'b1);
		send(mk(2'h0, 2'h2, 16'h7f80, 32'h00012345, 32'hfff00000, 1'b1), 1'b1);
		send(mk(2'h3, 2'h2, 16'hffff, 32'hffffffff, 32'h00000000, 1'b0), 1'b1);
		// Negative rounded word, zero fraction long, flat long range
		send(mk(2'h0, 2'h1, 16'h0440, 32'h0000fc18, 32'h0000fbb4, 1'b0), 1'b1);
		send(mk(2'h0, 2'h2, 16'h0500, 32'h87654321, 32'h00000010, 1'b0), 1'b1);
		send(mk(2'h2, 2'h2, 16'h31c7, 32'h9abcdef0, 32'h9abcdef0, 1'b1), 1'b1);
		// Random back-to-back traffic over every variant and size, with stalls
		for (k = 0; k < 120; k++) begin
			r = mk(2'(k % 4), 2'(k % 3), 16'($random(seed)), $random(seed), $random(seed),
				1'($random(seed)));
			send(r, ($random(seed) & 3) != 0);
		end
		@(posedge clk_i);
		#1;
		{req_valid_i, ce_i} = 2'b01;
		repeat (6) @(posedge clk_i);
		chk(q.size(), 0);
		wrap_up();
	end
endmodule
`default_nettype wire

// ---- tli_core.sv ----
// Table lookup and linear interpolation datapath top
`timescale 1ns/1ps
`default_nettype none
module tli_core
	import tli_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic req_valid_i,
	input wire tli_req_t req_i,
	output logic [TLI_OFS_MSB-TLI_OFS_LSB:0] entry_offset_o,
	output logic rsp_valid_o,
	output tli_rsp_t rsp_o
);
	logic [TLI_FRAC_W-1:0] frac;
	logic is_signed;
	logic is_rounded;
	logic [TLI_PROD_W-1:0] scaled;
	logic [TLI_PROD_W-1:0] scaled_r;
	logic stage_r;
	tli_req_t req_r;
	logic [TLI_RES_W-1:0] result_nxt;
	logic [TLI_PROD_W-TLI_FRAC_W-1:0] int_part;
	logic [TLI_DATA_W-1:0] lo_fit;
	logic [TLI_DATA_W-1:0] hi_fit;
	logic [TLI_PROD_W-1:0] exact_r;
	logic rounded_r;
	logic signed [TLI_RES_W+TLI_FRAC_W:0] round_err;

	// Operand widths below the long word, and half a result step
	localparam int TLI_BYTE_W = 8;
	localparam int TLI_WORD_W = 16;
	localparam int TLI_HALF_STEP = 1 << (TLI_FRAC_W - 1);

	// Pipeline: the taken request edge captures the scaled product and the offset,
	// the next enabled edge rounds or keeps the fraction and loads the result word.
	// A low enable holds both stages, so results keep their order across stalls.
	// The result is never cut back to the operand size; the caller narrows it.

	// Truncate to operand width, sign or zero extend back
	function automatic logic [TLI_DATA_W-1:0] fit(input logic [TLI_DATA_W-1:0] v,
		input tli_size_t sz, input logic sgn);
		logic [TLI_DATA_W-1:0] r;
		r = v;
		case (sz)
			TLI_SZ_BYTE: r = {{(TLI_DATA_W-TLI_BYTE_W){sgn & v[TLI_BYTE_W-1]}}, v[TLI_BYTE_W-1:0]};
			TLI_SZ_WORD: r = {{(TLI_DATA_W-TLI_WORD_W){sgn & v[TLI_WORD_W-1]}}, v[TLI_WORD_W-1:0]};
			default: r = v;
		endcase
		return r;
	endfunction

	// Split independent variable into offset and fraction
	assign frac = req_i.indep[TLI_FRAC_MSB:0];
	assign is_signed = ~req_i.variant[1];

	// Operands cut to size and extended by variant
	assign lo_fit = fit(req_i.entry_lo, req_i.size, is_signed);
	assign hi_fit = fit(req_i.entry_hi, req_i.size, is_signed);

	// Scaled product of fraction and end point difference
	tli_mac tli_mac_inst (
		.lo_i(lo_fit),
		.hi_i(hi_fit),
		.frac_i(frac),
		.is_signed_i(is_signed),
		.scaled_o(scaled)
	);

	// Stage one holds the product and request
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			stage_r <= 1'b0;
			scaled_r <= '0;
			req_r <= '0;
			entry_offset_o <= '0;
		end else if (ce_i) begin
			stage_r <= req_valid_i;
			if (req_valid_i) begin
				scaled_r <= scaled;
				req_r <= req_i;
				entry_offset_o <= req_i.indep[TLI_OFS_MSB:TLI_OFS_LSB];
			end
		end
	end

	// Round to nearest even or keep the fraction bits
	always_comb begin
		is_rounded = ~req_r.variant[0];
		int_part = scaled_r[TLI_PROD_W-1:TLI_FRAC_W];
		if (is_rounded) begin
			if (scaled_r[TLI_FRAC_W-1] && ((|scaled_r[TLI_FRAC_W-2:0]) || int_part[0]))
				int_part = int_part + 1'b1;
			result_nxt = TLI_RES_W'($signed(int_part)); // Keep the sign
		end else begin
			result_nxt = scaled_r[TLI_RES_W-1:0];
		end
	end

	// Output register
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			rsp_valid_o <= 1'b0;
			rsp_o <= '0;
		end else if (ce_i) begin
			rsp_valid_o <= stage_r;
			if (stage_r) begin
				rsp_o.value <= result_nxt;
				rsp_o.pair_mode <= req_r.pair_mode;
			end
		end
	end

	// Exact product behind the standing result, for the round to nearest check
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			exact_r <= '0;
			rounded_r <= 1'b0;
		end else if (ce_i && stage_r) begin
			exact_r <= scaled_r;
			rounded_r <= is_rounded;
		end
	end

	// Result scaled back up by the fraction width, minus the exact product
	always_comb begin
		round_err = $signed({rsp_o.value[TLI_RES_W-1], rsp_o.value, {TLI_FRAC_W{1'b0}}})
			- $signed({{(TLI_RES_W+TLI_FRAC_W+1-TLI_PROD_W){exact_r[TLI_PROD_W-1]}}, exact_r});
	end

	// Every taken request answers two enabled edges later
	chk_resp_follows: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		ce_i && req_valid_i ##1 ce_i |=> rsp_valid_o)
		else $error("response did not follow request");

	// Unrounded forms pass the product through untouched
	chk_unrounded_keeps: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		ce_i && stage_r && req_r.variant[0] |=> rsp_o.value == $past(scaled_r[TLI_RES_W-1:0]))
		else $error("unrounded result lost fraction");

	// A tie on an even integer stays put
	chk_round_even: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		ce_i && stage_r && !req_r.variant[0] && scaled_r[TLI_FRAC_W-1:0] == 8'h80
		&& !scaled_r[TLI_FRAC_W] |=> rsp_o.value[0] == 1'b0)
		else $error("tie not rounded to even");

	// A tie on an odd integer moves on to the even one
	chk_round_tie_odd: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		ce_i && stage_r && !req_r.variant[0] && scaled_r[TLI_FRAC_W-1:0] == 8'h80
		&& scaled_r[TLI_FRAC_W] |=> rsp_o.value[0] == 1'b0)
		else $error("odd tie not rounded to even");

	// Rounded results sit within half a step of the exact value
	chk_round_near: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		rsp_valid_o && rounded_r |-> round_err <= TLI_HALF_STEP && round_err >= -TLI_HALF_STEP)
		else $error("rounded result more than half a step off");

	// Offset comes from the upper byte of the independent variable
	chk_offset_split: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		ce_i && req_valid_i |=> entry_offset_o == $past(req_i.indep[TLI_OFS_MSB:TLI_OFS_LSB]))
		else $error("entry offset wrong");

	// Offset holds between taken requests
	chk_offset_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		!(ce_i && req_valid_i) |=> $stable(entry_offset_o))
		else $error("entry offset moved without a request");

	// No request, no answer
	chk_idle_quiet: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		ce_i && !req_valid_i ##1 ce_i |=> !rsp_valid_o)
		else $error("spurious response");

	// Valid drops once the inner stage runs empty
	chk_valid_pulse: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		ce_i && !stage_r |=> !rsp_valid_o)
		else $error("valid stayed high on an empty stage");

	// A zero fraction leaves no fraction bits
	chk_zero_frac: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		ce_i && req_valid_i && req_i.indep[TLI_FRAC_MSB:0] == 8'h00 && req_i.size == TLI_SZ_LONG
		|=> scaled_r[TLI_FRAC_W-1:0] == 8'h00)
		else $error("zero fraction gave fraction bits");

	// A zero fraction on a rounded long request returns the selected entry itself
	chk_frac_zero_end: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		ce_i && stage_r && !req_r.variant[0] && req_r.size == TLI_SZ_LONG
		&& req_r.indep[TLI_FRAC_MSB:0] == 8'h00
		|=> rsp_o.value[TLI_DATA_W-1:0] == $past(req_r.entry_lo))
		else $error("zero fraction did not return the entry");

	// Equal end points give that value at any fraction on a rounded long request
	chk_flat_range: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		ce_i && stage_r && !req_r.variant[0] && req_r.size == TLI_SZ_LONG
		&& req_r.entry_lo == req_r.entry_hi
		|=> rsp_o.value[TLI_DATA_W-1:0] == $past(req_r.entry_lo))
		else $error("flat range moved the result");

	// Unsigned products never go negative
	chk_unsigned_pos: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		ce_i && req_valid_i && req_i.variant[1] |=> !scaled_r[TLI_PROD_W-1])
		else $error("unsigned product negative");

	// Unsigned rounded results never carry a sign
	chk_unsigned_result: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		ce_i && stage_r && req_r.variant == TLI_UNSIGNED_ROUNDED |=> !rsp_o.value[TLI_RES_W-1])
		else $error("unsigned result came out negative");

	// Pair mode rides along with its result
	chk_pair_tag: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		ce_i && req_valid_i ##1 ce_i |=> rsp_o.pair_mode == $past(req_i.pair_mode, 2))
		else $error("pair mode not carried");

	// Result word holds until the next result
	chk_result_holds: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		!(ce_i && stage_r) |=> $stable(rsp_o))
		else $error("result changed without a new result");

	// A low enable freezes outputs and the inner stage
	chk_freeze: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		!ce_i |=> $stable(rsp_o) && $stable(rsp_valid_o))
		else $error("state moved while disabled");
	chk_freeze_stage: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		!ce_i |=> $stable(stage_r) && $stable(scaled_r) && $stable(entry_offset_o))
		else $error("inner stage moved while disabled");

	// Synchronous reset clears every output
	chk_reset_clear: assert property (@(posedge clk_i)
		!reset_n_i |=> !rsp_valid_o && rsp_o == '0 && entry_offset_o == '0)
		else $error("outputs not cleared by reset");
endmodule
`default_nettype wire

// ---- tli_mac.sv ----
// Multiply stage: fraction times entry difference
`timescale 1ns/1ps
`default_nettype none
module tli_mac
	import tli_pkg::*;
(
	input wire logic [TLI_DATA_W-1:0] lo_i,
	input wire logic [TLI_DATA_W-1:0] hi_i,
	input wire logic [TLI_FRAC_W-1:0] frac_i,
	input wire logic is_signed_i,
	output logic [TLI_PROD_W-1:0] scaled_o
);
	logic [TLI_DATA_W:0] lo_x;
	logic [TLI_DATA_W:0] hi_x;
	logic [TLI_DATA_W+1:0] diff;
	logic [TLI_PROD_W-1:0] diff_x;
	logic [TLI_PROD_W-1:0] lo_s;

	// Extend by signedness, then lo*256 + frac*(hi-lo)
	always_comb begin
		lo_x = {is_signed_i & lo_i[TLI_DATA_W-1], lo_i};
		hi_x = {is_signed_i & hi_i[TLI_DATA_W-1], hi_i};
		diff = {hi_x[TLI_DATA_W], hi_x} - {lo_x[TLI_DATA_W], lo_x};
		diff_x = {{(TLI_PROD_W-TLI_DATA_W-2){diff[TLI_DATA_W+1]}}, diff};
		lo_s = {{(TLI_PROD_W-TLI_DATA_W-1-TLI_FRAC_W){lo_x[TLI_DATA_W]}}, lo_x,
			{TLI_FRAC_W{1'b0}}};
		scaled_o = lo_s + TLI_PROD_W'(diff_x * {{(TLI_PROD_W-TLI_FRAC_W){1'b0}}, frac_i});
	end
endmodule
`default_nettype wire

// ---- tli_pkg.sv ----
// Package for the table lookup and interpolation datapath
// Summary of operation
// - The entry offset is bits 15 to 8 of the independent variable and the fraction is bits 7 to 0.
// - The result is the selected entry plus fraction times (next entry minus entry) over 256.
// - The signed rounded variant rounds the result to an integer by round to nearest even.
// - Unrounded variants return the result with 8 fraction bits kept below the radix point.
// - A register pair may supply both end points, rounded in the signed rounded form; here pair_mode is only carried along and rounding follows the variant.
// - Four variants exist, signed or unsigned, rounded or unrounded, for byte, word or long.
// - End points come from an n-element table in memory or from a pair of data registers.
package tli_pkg;
	localparam int TLI_FRAC_W = 8;
	localparam int TLI_OFS_LSB = 8;
	localparam int TLI_OFS_MSB = 15;
	localparam int TLI_FRAC_MSB = 7;
	localparam int TLI_DATA_W = 32;
	localparam int TLI_RES_W = 40;
	localparam int TLI_PROD_W = 44;

	// Operand size codes
	typedef enum logic [1:0] {
		TLI_SZ_BYTE = 2'h0,
		TLI_SZ_WORD = 2'h1,
		TLI_SZ_LONG = 2'h2
	} tli_size_t;

	// Variant select, bit 1 unsigned, bit 0 unrounded
	typedef enum logic [1:0] {
		TLI_SIGNED_ROUNDED = 2'h0,
		TLI_SIGNED_UNROUNDED = 2'h1,
		TLI_UNSIGNED_ROUNDED = 2'h2,
		TLI_UNSIGNED_UNROUNDED = 2'h3
	} tli_variant_t;

	// One interpolation request
	typedef struct packed {
		tli_variant_t variant;
		tli_size_t size;
		logic [15:0] indep;
		logic [TLI_DATA_W-1:0] entry_lo;
		logic [TLI_DATA_W-1:0] entry_hi;
		logic pair_mode;
	} tli_req_t;

	// One interpolation answer
	typedef struct packed {
		logic [TLI_RES_W-1:0] value;
		logic pair_mode;
	} tli_rsp_t;
endpackage
